// ### logic/step_word_diag_graph_cmd.sv
// command interpreter: fieldbus compact words over apb, parallel port
// diagnostic path, event-step word decode and graph acquisition control.
// assumes graph sample storage outside, answering in the same cycle as the registered request.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module step_word_diag_graph_cmd (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire cmd_pkg::apb_req_t apb_in,
  output cmd_pkg::apb_rsp_t apb_out,
  input wire logic step_valid_in,
  output logic step_ready_out,
  input wire cmd_pkg::step_cmd_word_t step_cmd_in,
  input wire cmd_pkg::link_word_t step_link_in,
  input wire logic [cmd_pkg::AXIS_W-1:0] step_axis_in,
  output logic disp_valid_out,
  input wire logic disp_ready_in,
  output cmd_pkg::dispatch_t disp_out,
  input wire logic dio_strobe_in,
  input wire logic [cmd_pkg::WORD_W-1:0] dio_word_in,
  output logic dio_ack_out,
  output logic [cmd_pkg::BYTE_W-1:0] dio_byte_out,
  output cmd_pkg::graph_rd_t graph_rd_out,
  input wire logic [cmd_pkg::WORD_W-1:0] graph_rd_data_in,
  output logic [cmd_pkg::NUM_AXES-1:0] acq_wr_mask_out,
  output logic [cmd_pkg::NUM_AXES-1:0][cmd_pkg::SAMPLE_W-1:0] acq_sample_out
);
  import cmd_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ISSUE = 2'b01,
    S_CAPTURE = 2'b11,
    S_DONE = 2'b10
  } scan_state_t;

  localparam logic [AXIS_W-1:0] AXIS_LAST = AXIS_W'(NUM_AXES - 1);

  // software-visible registers
  logic [WORD_W-1:0] sync_out_reg; // master's submit counter
  logic [WORD_W-1:0] sync_in_reg; // device's done counter
  logic [WORD_W-1:0] plot_time_reg; // clocks per sample, 0 acts as 1
  logic [NUM_AXES-1:0] graph_dis_reg; // per-axis graph disable
  logic [WORD_W-1:0] cmd_reg [NUM_AXES]; // command output words
  logic [WORD_W-1:0] data_reg [NUM_AXES]; // data output words
  logic [WORD_W-1:0] status_reg [NUM_AXES]; // status input words
  logic [WORD_W-1:0] din_reg [NUM_AXES]; // data input words
  logic [31:0] prdata_reg; // read data, loaded in setup phase
  logic [31:0] prdata_next;
  logic hit_next; // address maps to a register

  // scan sequencer
  scan_state_t state_reg;
  logic [AXIS_W-1:0] axis_reg; // axis being served this scan
  logic [WORD_W-1:0] cur_cmd;
  graph_cmd_t cur_graph;
  logic in_range;
  graph_rd_t graph_rd_reg;

  // acquisition
  logic [NUM_AXES-1:0] acq_active_reg;
  logic [NUM_AXES-1:0] start_vec; // start requests this cycle
  logic [WORD_W-1:0] plot_cnt_reg;
  logic plot_tick; // one-cycle sample enable
  logic [NUM_AXES-1:0] acq_wr_mask_reg;
  logic [SAMPLE_W-1:0] sample_reg [NUM_AXES];
  logic [SAMPLE_W-1:0] wr_idx_reg [NUM_AXES]; // index paired with the pulse

  // step dispatch
  dispatch_t step_decoded;
  logic disp_fire;

  // parallel port
  logic strobe_meta_reg; // first synchroniser stage only
  logic strobe_sync_reg;
  logic strobe_prev_reg;
  logic [WORD_W-1:0] word_meta_reg;
  logic [WORD_W-1:0] word_sync_reg;
  logic data_phase_reg; // next strobe carries a data word
  logic last_diag_reg; // previous command was diagnostic
  logic dio_ack_reg;
  logic [BYTE_W-1:0] dio_byte_reg;

  logic apb_setup;
  logic apb_access;
  logic [AXIS_W-1:0] apb_axis;
  logic [6:0] apb_region;

  assign apb_setup = apb_in.psel && !apb_in.penable;
  assign apb_access = apb_in.psel && apb_in.penable;
  assign apb_axis = apb_in.paddr[4:2];
  assign apb_region = apb_in.paddr[11:5];

  // zero wait states; the error flag is held from the setup decode
  logic hit_reg;
  assign apb_out.pready = apb_access;
  assign apb_out.pslverr = apb_access && !hit_reg;
  assign apb_out.prdata = prdata_reg;

  // read decode, unmapped words read zero and flag an error
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (apb_in.paddr)
      ADDR_SYNC_OUT: prdata_next = {16'h0000, sync_out_reg};
      ADDR_SYNC_IN: prdata_next = {16'h0000, sync_in_reg};
      ADDR_PLOT_TIME: prdata_next = {16'h0000, plot_time_reg};
      ADDR_GRAPH_DIS: prdata_next = {24'h00_0000, graph_dis_reg};
      ADDR_ACQ_ACTIVE: prdata_next = {24'h00_0000, acq_active_reg};
      default:
      begin
        if (apb_in.paddr[1:0] != 2'h0)
        begin
          hit_next = 1'b0;
        end
        else if (apb_region == REGION_CMD)
        begin
          prdata_next = {16'h0000, cmd_reg[apb_axis]};
        end
        else if (apb_region == REGION_DATA)
        begin
          prdata_next = {16'h0000, data_reg[apb_axis]};
        end
        else if (apb_region == REGION_STATUS)
        begin
          prdata_next = {16'h0000, status_reg[apb_axis]};
        end
        else if (apb_region == REGION_DIN)
        begin
          prdata_next = {16'h0000, din_reg[apb_axis]};
        end
        else
        begin
          hit_next = 1'b0;
        end
      end
    endcase
  end

  // capture read data and decode result in the setup cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      prdata_reg <= 32'h0000_0000;
      hit_reg <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_reg <= prdata_next;
      hit_reg <= hit_next;
    end
  end

  // software-written registers, written only at the access edge
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      sync_out_reg <= WORD_ZERO;
      plot_time_reg <= PLOT_TIME_RESET;
      graph_dis_reg <= '0;
      for (int i = 0; i < NUM_AXES; i++)
      begin
        cmd_reg[i] <= WORD_ZERO;
        data_reg[i] <= WORD_ZERO;
      end
    end
    else if (apb_access && apb_in.pwrite && hit_reg)
    begin
      // master bumps the counter to submit the words
      if (apb_in.paddr == ADDR_SYNC_OUT)
        sync_out_reg <= apb_in.pwdata[WORD_W-1:0];
      else if (apb_in.paddr == ADDR_PLOT_TIME)
        plot_time_reg <= apb_in.pwdata[WORD_W-1:0];
      else if (apb_in.paddr == ADDR_GRAPH_DIS)
        graph_dis_reg <= apb_in.pwdata[NUM_AXES-1:0];
      else if (apb_region == REGION_CMD)
        cmd_reg[apb_axis] <= apb_in.pwdata[WORD_W-1:0];
      else if (apb_region == REGION_DATA)
        data_reg[apb_axis] <= apb_in.pwdata[WORD_W-1:0];
    end
  end

  assign cur_cmd = cmd_reg[axis_reg];
  assign cur_graph = cur_cmd; // select 15:10, sample 9:0
  assign in_range = cur_graph.graph_select_index <= GSI_LAST;

  // scan: one pass over all axes per sync change, one word each
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= S_IDLE;
      axis_reg <= '0;
      sync_in_reg <= WORD_ZERO;
      graph_rd_reg <= '0;
    end
    else
    begin
      graph_rd_reg.en <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          axis_reg <= '0;
          if (sync_out_reg != sync_in_reg)
            state_reg <= S_ISSUE;
        end
        S_ISSUE:
        begin
          // index minus first gives axis*6+type in order
          if (is_graph(cur_cmd) && in_range)
          begin
            graph_rd_reg.en <= 1'b1;
            graph_rd_reg.sel <= cur_graph.graph_select_index - GSI_FIRST;
            graph_rd_reg.sample <= cur_graph.sample;
          end
          state_reg <= S_CAPTURE;
        end
        S_CAPTURE:
        begin
          axis_reg <= axis_reg + 1'b1;
          state_reg <= (axis_reg == AXIS_LAST) ? S_DONE : S_ISSUE;
        end
        S_DONE:
        begin
          // answers are valid once the counters match
          sync_in_reg <= sync_out_reg;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // input words for the axis being captured
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < NUM_AXES; i++)
      begin
        status_reg[i] <= WORD_ZERO;
        din_reg[i] <= WORD_ZERO;
      end
    end
    else if (state_reg == S_CAPTURE)
    begin
      status_reg[axis_reg] <= cur_cmd;
      if (is_diag(cur_cmd))
        din_reg[axis_reg] <= data_reg[axis_reg]; // echo both
      else if (is_graph(cur_cmd))
        // out-of-range select never reaches storage
        din_reg[axis_reg] <= in_range ? graph_rd_data_in : WORD_ZERO;
    end
  end

  assign graph_rd_out = graph_rd_reg;

  // step word decode: zero axes byte means the running axis
  always_comb
  begin
    step_decoded = '0;
    step_decoded.code = step_cmd_in.code;
    if (step_cmd_in.axes == 8'h00)
      step_decoded.axis_mask[step_axis_in] = 1'b1;
    else
      step_decoded.axis_mask = step_cmd_in.axes[NUM_AXES-1:0];
    step_decoded.next_step = step_link_in.next_step;
    step_decoded.link_type = step_link_in.link_type;
  end

  // a stalled receiver backs up into the step source
  two_entry_buffer #(
    .WIDTH($bits(dispatch_t))
  ) u_disp_buf (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(step_valid_in),
    .in_ready_out(step_ready_out),
    .in_data_in(step_decoded),
    .out_valid_out(disp_valid_out),
    .out_ready_in(disp_ready_in),
    .out_data_out(disp_out)
  );

  assign disp_fire = disp_valid_out && disp_ready_in;

  // start requests from the scan and from accepted dispatches
  always_comb
  begin
    start_vec = '0;
    if ((state_reg == S_ISSUE) && !is_graph(cur_cmd) &&
        (cur_cmd[15:12] == DIAG_HI_NIBBLE) && is_trigger(cur_cmd[7:0]))
      start_vec[axis_reg] = 1'b1;
    if (disp_fire && is_trigger(disp_out.code))
      start_vec = start_vec | disp_out.axis_mask;
    // disabled axes keep their last graph
    start_vec = start_vec & ~graph_dis_reg;
  end

  // sample-rate divider from the plot time value
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      plot_cnt_reg <= WORD_ZERO;
    else if (plot_tick)
      plot_cnt_reg <= WORD_ZERO;
    else
      plot_cnt_reg <= plot_cnt_reg + 1'b1;
  end

  // zero plot time would stall sampling, so it behaves as one
  assign plot_tick = (plot_cnt_reg + 1'b1 >= plot_time_reg);

  // per-axis acquisition: fills all six arrays at one index per tick
  generate
    for (genvar a = 0; a < NUM_AXES; a++)
    begin : g_acq
      always_ff @(posedge ref_clk_in)
      begin
        if (!rst_n_in)
        begin
          acq_active_reg[a] <= 1'b0;
          sample_reg[a] <= '0;
          wr_idx_reg[a] <= '0;
          acq_wr_mask_reg[a] <= 1'b0;
        end
        else
        begin
          acq_wr_mask_reg[a] <= 1'b0;
          if (start_vec[a])
          begin
            // only a new start overwrites stored samples
            acq_active_reg[a] <= 1'b1;
            sample_reg[a] <= '0;
          end
          else if (acq_active_reg[a] && plot_tick)
          begin
            // the pulse carries the index before the bump, 0 first
            acq_wr_mask_reg[a] <= 1'b1;
            wr_idx_reg[a] <= sample_reg[a];
            sample_reg[a] <= sample_reg[a] + 1'b1;
            if (sample_reg[a] == SAMPLE_LAST)
              acq_active_reg[a] <= 1'b0;
          end
        end
      end
      assign acq_sample_out[a] = wr_idx_reg[a];
    end
  endgenerate

  assign acq_wr_mask_out = acq_wr_mask_reg;

  // parallel port pins cross in through two flops
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      strobe_meta_reg <= 1'b0;
      strobe_sync_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
      word_meta_reg <= WORD_ZERO;
      word_sync_reg <= WORD_ZERO;
    end
    else
    begin
      strobe_meta_reg <= dio_strobe_in;
      strobe_sync_reg <= strobe_meta_reg;
      strobe_prev_reg <= strobe_sync_reg;
      word_meta_reg <= dio_word_in;
      word_sync_reg <= word_meta_reg;
    end
  end

  // one byte per strobe; ack follows the strobe level
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      data_phase_reg <= 1'b0;
      last_diag_reg <= 1'b0;
      dio_ack_reg <= 1'b0;
      dio_byte_reg <= 8'h00;
    end
    else if (strobe_sync_reg && !strobe_prev_reg)
    begin
      dio_ack_reg <= 1'b1;
      data_phase_reg <= ~data_phase_reg;
      if (!data_phase_reg)
      begin
        last_diag_reg <= is_diag(word_sync_reg);
        // graph words get no data on this port
        dio_byte_reg <= (is_diag(word_sync_reg) && !is_graph(word_sync_reg))
          ? word_sync_reg[7:0] : 8'h00;
      end
      else
      begin
        dio_byte_reg <= last_diag_reg ? word_sync_reg[7:0] : 8'h00;
      end
    end
    else if (!strobe_sync_reg)
    begin
      dio_ack_reg <= 1'b0;
    end
  end

  assign dio_ack_out = dio_ack_reg;
  assign dio_byte_out = dio_byte_reg;

endmodule
`default_nettype wire

// ### logic/cmd_pkg.sv
// constants, carrier types and shared decode for the step-word, diagnostic
// and graph-download command interpreter.
// assumes a single 100 MHz clock domain and an apb master on the same clock.
package cmd_pkg;

  localparam int NUM_AXES = 8;
  localparam int AXIS_W = 3;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int SAMPLE_W = 10;
  localparam int GSI_W = 6;
  localparam int GRAPHS_PER_AXIS = 6;

  // graph selection window and sample count
  localparam logic [GSI_W-1:0] GSI_FIRST = 6'h08;
  localparam logic [GSI_W-1:0] GSI_LAST = 6'h37;
  localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = 10'h3ff;

  // commands that start a graph acquisition
  localparam logic [7:0] CODE_GO = 8'h47;
  localparam logic [7:0] CODE_MOVE_REL = 8'h52;
  localparam logic [7:0] CODE_OPEN_LOOP = 8'h4f;
  localparam logic [7:0] CODE_SINE = 8'h53;
  localparam logic [7:0] CODE_SPLINE = 8'h46;
  localparam logic [7:0] CODE_START_GRAPH = 8'h59;

  // diagnostic pattern nibbles
  localparam logic [3:0] DIAG_HI_NIBBLE = 4'h0;
  localparam logic [3:0] DIAG_MID_NIBBLE = 4'hf;

  // apb map: single registers by byte address
  localparam logic [11:0] ADDR_SYNC_OUT = 12'h000;
  localparam logic [11:0] ADDR_SYNC_IN = 12'h004;
  localparam logic [11:0] ADDR_PLOT_TIME = 12'h008;
  localparam logic [11:0] ADDR_GRAPH_DIS = 12'h00c;
  localparam logic [11:0] ADDR_ACQ_ACTIVE = 12'h010;
  // per-axis arrays: region is paddr[11:5], axis is paddr[4:2]
  localparam logic [6:0] REGION_CMD = 7'h08;
  localparam logic [6:0] REGION_DATA = 7'h09;
  localparam logic [6:0] REGION_STATUS = 7'h0a;
  localparam logic [6:0] REGION_DIN = 7'h0b;

  // reset values
  localparam logic [WORD_W-1:0] PLOT_TIME_RESET = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

  typedef struct packed {
    logic [7:0] axes;
    logic [7:0] code;
  } step_cmd_word_t;

  typedef struct packed {
    logic [7:0] next_step;
    logic [7:0] link_type;
  } link_word_t;

  typedef struct packed {
    logic [NUM_AXES-1:0] axis_mask;
    logic [7:0] code;
    logic [7:0] next_step;
    logic [7:0] link_type;
  } dispatch_t;

  typedef struct packed {
    logic [GSI_W-1:0] graph_select_index;
    logic [SAMPLE_W-1:0] sample;
  } graph_cmd_t;

  typedef struct packed {
    logic en;
    logic [GSI_W-1:0] sel;
    logic [SAMPLE_W-1:0] sample;
  } graph_rd_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // diagnostic: bits 15:12 zero, bits 7:4 all ones, others ignored
  function automatic logic is_diag(input logic [WORD_W-1:0] w);
    return (w[15:12] == DIAG_HI_NIBBLE) && (w[7:4] == DIAG_MID_NIBBLE);
  endfunction

  // graph download: selection index at or above the first graph
  function automatic logic is_graph(input logic [WORD_W-1:0] w);
    graph_cmd_t g;
    g = w;
    return g.graph_select_index >= GSI_FIRST;
  endfunction

  function automatic logic is_trigger(input logic [7:0] code);
    return (code == CODE_GO) || (code == CODE_MOVE_REL) ||
      (code == CODE_OPEN_LOOP) || (code == CODE_SINE) ||
      (code == CODE_SPLINE) || (code == CODE_START_GRAPH);
  endfunction

endpackage

// ### logic/two_entry_buffer.sv
// two-entry valid/ready buffer holding decoded step dispatches.
// assumes both sides on the same clock; in_ready_out is honest.
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem_reg [2]; // storage entries
  logic wr_ptr_reg; // next entry to fill
  logic rd_ptr_reg; // next entry to drain
  logic [1:0] count_reg; // entries held
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  // full stalls the source so a stalled sink loses nothing
  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_ptr_reg];

  // storage write
  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers and occupancy
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ### verification/cmd_chk_sva.sv
// checker: port-level timing of the command interpreter
// assumes it is bound onto step_word_diag_graph_cmd, one clock domain
`timescale 1ns/1ns
`default_nettype none
module cmd_chk
  import cmd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire cmd_pkg::apb_req_t apb_in,
  input wire cmd_pkg::apb_rsp_t apb_out,
  input wire logic step_valid_in,
  input wire logic step_ready_out,
  input wire logic disp_valid_out,
  input wire logic disp_ready_in,
  input wire cmd_pkg::dispatch_t disp_out,
  input wire logic dio_strobe_in,
  input wire logic dio_ack_out,
  input wire logic [cmd_pkg::BYTE_W-1:0] dio_byte_out,
  input wire cmd_pkg::graph_rd_t graph_rd_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // a step word taken into the two-entry buffer
  sequence step_take;
    step_valid_in && step_ready_out;
  endsequence
  // strobe newly raised while the port is idle
  sequence dio_start;
    $rose(dio_strobe_in) && !dio_ack_out;
  endsequence
  apb_ready_a: assert property (apb_in.psel && apb_in.penable |-> apb_out.pready)
    else $error("pready missing in access phase");
  apb_err_a: assert property (apb_out.pslverr |-> apb_in.psel && apb_in.penable)
    else $error("pslverr outside access phase");
  step_take_a: assert property (step_take |=> disp_valid_out)
    else $error("taken step word not offered");
  disp_hold_a: assert property (disp_valid_out && !disp_ready_in |=> disp_valid_out && $stable(disp_out))
    else $error("stalled dispatch changed");
  buf_full_a: assert property (!step_ready_out |-> disp_valid_out)
    else $error("ready low with empty buffer");
  disp_mask_a: assert property (disp_valid_out |-> disp_out.axis_mask != 8'h00)
    else $error("dispatch with empty axis mask");
  graph_once_a: assert property (graph_rd_out.en |=> !graph_rd_out.en)
    else $error("graph read longer than one cycle");
  dio_ack_a: assert property (dio_start |-> ##[2:6] dio_ack_out)
    else $error("strobe not acknowledged in time");
  dio_byte_a: assert property (dio_ack_out && $past(dio_ack_out) |-> $stable(dio_byte_out))
    else $error("returned byte moved during ack");
endmodule
`default_nettype wire

// ### verification/graph_store_model.sv
// graph sample storage stand-in: answers while the registered en stands
// assumes one clock; the word is scrambled whenever no read is pending
`timescale 1ns/1ns
`default_nettype none
module graph_store_model
  import cmd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire cmd_pkg::graph_rd_t rd_in,
  output logic [cmd_pkg::WORD_W-1:0] data_out
);
  logic [cmd_pkg::WORD_W-1:0] stale = 16'h0000; // word shown between reads
  // stale word toggles so a capture outside en never looks valid
  always @(posedge ref_clk_in)
  begin
    stale <= ~stale;
  end
  // the request is already a flop, so the array answers in its cycle
  // each select owns its samples; any subset may be fetched
  assign data_out = rd_in.en ? ({rd_in.sel, rd_in.sample} ^ 16'ha5a5)
    : stale; // per-select pattern
endmodule
`default_nettype wire

// ### verification/tb_step_word_diag_graph_cmd.sv
// self-checking bench for the command interpreter
// assumes graph_store_model as storage; this bench is the apb master
`timescale 1ns/1ns
`default_nettype none
module tb_step_word_diag_graph_cmd;
  import cmd_pkg::*;
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // sync reset, active low
  apb_req_t req = '0; // register bus request
  apb_rsp_t rsp;
  logic sv = 1'b0; // step word offered
  logic sr;
  step_cmd_word_t sc = '0;
  link_word_t sl = '0;
  logic [2:0] sa = 3'h0; // axis running the sequence
  logic dv;
  logic dr = 1'b0; // sink stalls at first
  dispatch_t dsp;
  logic stb = 1'b0; // parallel strobe
  logic [15:0] dw = 16'h0000;
  logic ack;
  logic [7:0] db;
  graph_rd_t grd;
  logic [15:0] gd;
  logic [7:0] wm;
  logic [7:0][9:0] asmp;
  int error_cnt = 0;
  int tests_run = 0;
  int m1_cnt = 0; // write pulses on the disabled axis
  logic seen0 = 1'b0;
  logic [9:0] samp0 = 10'h3ff;
  logic lerr; // pslverr of the last transfer
  logic [31:0] rd;
  logic [15:0] cw [8];
  logic [15:0] dd [8];
  logic [15:0] ed [8];
  dispatch_t q [$]; // expected dispatches in order
  always #5 clk = ~clk;
  step_word_diag_graph_cmd dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .apb_in(req), .apb_out(rsp), .step_valid_in(sv), .step_ready_out(sr),
    .step_cmd_in(sc), .step_link_in(sl), .step_axis_in(sa),
    .disp_valid_out(dv), .disp_ready_in(dr), .disp_out(dsp),
    .dio_strobe_in(stb), .dio_word_in(dw), .dio_ack_out(ack),
    .dio_byte_out(db), .graph_rd_out(grd), .graph_rd_data_in(gd),
    .acq_wr_mask_out(wm), .acq_sample_out(asmp));
  graph_store_model store (.ref_clk_in(clk), .rd_in(grd), .data_out(gd));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer; waits on pready, assumes no fixed latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    lerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // word is set up a cycle before the strobe rises
  task dio(input logic [15:0] w, input logic [7:0] e);
    @(posedge clk);
    dw <= w;
    @(posedge clk);
    stb <= 1'b1;
    while (ack !== 1'b1)
      @(posedge clk);
    chk(db, e); // returned byte
    stb <= 1'b0;
    while (ack !== 1'b0)
      @(posedge clk);
  endtask
  task push(input logic [7:0] ax, input logic [7:0] c,
    input logic [15:0] l, input logic [2:0] r);
    @(posedge clk);
    sv <= 1'b1;
    sc <= {ax, c};
    sl <= l;
    sa <= r;
    q.push_back({(ax != 8'h00) ? ax : (8'h01 << r), c, l});
    do
    begin
      @(posedge clk);
    end
    while (sr !== 1'b1);
    sv <= 1'b0;
  endtask
  // count acquisition writes on axis 1, record the first write index on axis 0
  always @(posedge clk)
  begin
    if (wm[1] === 1'b1)
      m1_cnt <= m1_cnt + 1;
    if (wm[0] === 1'b1 && !seen0)
    begin
      seen0 <= 1'b1;
      samp0 <= asmp[0];
    end
  end
  // hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end
  initial
  begin
    int i;
    logic [31:0] r;
    void'($urandom(32'h5c575e18));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_PLOT_TIME, 32'h0);
    chk(rd, 32'h1); // plot time after reset
    apb(1'b0, 12'hffc, 32'h0);
    chk({lerr, rd[30:0]}, 32'h80000000); // unmapped read refused
    r = $urandom;
    cw = '{16'h03f5, 16'h0cfa, 16'h2405, 16'hf3ff,
      {4'h0, r[11:8], 4'hf, r[3:0]}, {8'h00, CODE_START_GRAPH}, 16'h0,
      16'h0};
    dd = '{16'h1248, 16'h8421, 16'h5555, 16'h5555, r[31:16],
      16'h0, 16'h0, 16'h0};
    ed = '{16'h1248, 16'h8421, {6'd1, 10'd5} ^ 16'ha5a5, 16'h0,
      r[31:16], 16'h0, 16'h0, 16'h0};
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'(12'h100 + 4 * i), {16'h0, cw[i]});
      apb(1'b1, 12'(12'h120 + 4 * i), {16'h0, dd[i]});
    end
    apb(1'b1, ADDR_SYNC_OUT, 32'h1);
    rd = 32'h0;
    for (i = 0; i < 40 && rd !== 32'h1; i++)
      apb(1'b0, ADDR_SYNC_IN, 32'h0);
    chk(rd, 32'h1); // sync input follows
    for (i = 0; i < 8; i++)
    begin
      apb(1'b0, 12'(12'h140 + 4 * i), 32'h0);
      chk(rd, {16'h0, cw[i]}); // status echo
      apb(1'b0, 12'(12'h160 + 4 * i), 32'h0);
      chk(rd, {16'h0, ed[i]}); // data
    end
    apb(1'b1, ADDR_PLOT_TIME, 32'h4);
    apb(1'b1, ADDR_GRAPH_DIS, 32'h2);
    push(8'h03, CODE_GO, 16'h0a44, 3'h0);
    push(8'h00, 8'h10, 16'h0512, 3'h5);
    @(posedge clk);
    chk(sr, 1'b0); // two held, no room left
    dr <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      chk(dsp, q.pop_front()); // dispatch
    end
    repeat (40) @(posedge clk);
    apb(1'b0, ADDR_ACQ_ACTIVE, 32'h0);
    chk(rd, 32'h21); // scan start on 5, dispatch on 0
    chk(m1_cnt, 32'h0); // disabled axis untouched
    chk({seen0, samp0}, 32'h400); // fill starts at zero
    dio(16'h00f0, 8'hf0);
    dio(16'h000f, 8'h0f);
    dio(16'h0047, 8'h00);
    dio(16'h1234, 8'h00);
    dio(16'h2405, 8'h00); // graph word refused here
    dio(16'h0102, 8'h00);
    r = $urandom;
    dio({4'h0, r[11:8], 4'hf, r[3:0]}, {4'hf, r[3:0]});
    dio(r[31:16], r[23:16]);
    final_report;
  end
endmodule
bind step_word_diag_graph_cmd cmd_chk chk_u (.ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in), .apb_in(apb_in), .apb_out(apb_out),
  .step_valid_in(step_valid_in), .step_ready_out(step_ready_out),
  .disp_valid_out(disp_valid_out), .disp_ready_in(disp_ready_in),
  .disp_out(disp_out), .dio_strobe_in(dio_strobe_in),
  .dio_ack_out(dio_ack_out), .dio_byte_out(dio_byte_out),
  .graph_rd_out(graph_rd_out));
`default_nettype wire
